// ==== design/i2cws_top.sv ====
// Two-wire slave control port with control-write sequencer
// How it works
// - Data line is only pulled low or released, never driven high.
// - Bus address byte 0x34 selects this device, last bit is direction.
// - Direction bit one means read, zero means write.
// - After a start, eight bits are shifted in MSB first as address byte.
// - Matching address is acknowledged by pulling data low for one clock pulse.
// - Mismatched address returns to idle without acknowledge.
// - Rising data while clock high is a stop and ends the transfer.
// - After a not-acknowledge from the master the port awaits a new start.
// - Start or stop at an unexpected point abandons the transfer.
// - Below 0x3000: 32-bit register address, 16-bit data words.
// - At or above 0x3000: 32-bit register address, 32-bit data words.
// - Register address advances after every data word written and every read word the master acknowledges.
// - Sixteen trigger bits each start a sequence at their own start index.
// - A start index of 0x1FF aborts the sequence instead.
// - Requests arriving while busy are queued and run in turn.
// - Launch bit with enable runs from launch index, waiting if busy.
// - Abort stops only the running sequence; pending ones stay.
// - Memory holds 508 commands at 0x3000 through 0x33F6.
// - Launch bit clears itself when its sequence finishes.
// - Memory keeps its contents through reset; host reloads after power-up.
// - Access and execution need no system clock.
// - Start index is nine bits; 0 to 507 usable.
`timescale 1ns/10ps
`default_nettype none
module i2cws_top
    import i2cws_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    // Two-wire pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // Register map outside this block
    input  wire logic [31:0] ext_rd_data,
    output logic [31:0]      reg_rd_addr,
    output i2cws_wr_t        reg_wr,
    // Status
    output logic             seq_busy
);
    localparam logic [7:0] DEV_ID = `I2CWS_DEV_ID;

    i2cws_state_t s_r;
    i2cws_state_t s_nxt;
    logic         scl_nf;
    logic         sda_nf;
    logic         scl_rise;
    logic         scl_fall;
    logic         start_c;
    logic         stop_c;
    logic         wr_word;
    logic [31:0]  wd;
    logic         load_tx;
    logic         abort_req;
    logic         seq_issue;
    logic         seq_done;
    logic [31:0]  cmd;
    logic [8:0]   pick_idx;
    logic [3:0]   k;
    logic [4:0]   wslot;

    function automatic logic wide(input logic [31:0] a);
        return a >= `I2CWS_WIDE_OFS;
    endfunction

    function automatic logic [4:0] idx_slot(input logic [31:0] a);
        if (a >= `I2CWS_IDXA_OFS && a < `I2CWS_IDXA_OFS + `I2CWS_IDXA_CNT)
            return 5'(a - `I2CWS_IDXA_OFS);
        else if (a >= `I2CWS_IDXB_OFS && a < `I2CWS_IDXB_OFS + `I2CWS_IDXB_CNT)
            return 5'(a - `I2CWS_IDXB_OFS + `I2CWS_IDXA_CNT);
        else if (a >= `I2CWS_IDXC_OFS && a < `I2CWS_IDXC_OFS + `I2CWS_IDXC_CNT)
            return 5'(a - `I2CWS_IDXC_OFS + `I2CWS_IDXA_CNT + `I2CWS_IDXB_CNT);
        else
            return 5'h10;
    endfunction

    function automatic logic mem_hit(input logic [31:0] a);
        return a >= `I2CWS_MEM_OFS && a <= `I2CWS_MEM_LAST_OFS && !a[0];
    endfunction

    function automatic logic [8:0] mem_slot(input logic [31:0] a);
        logic [31:0] t;
        t = (a - `I2CWS_MEM_OFS) >> 1;
        return t[8:0];
    endfunction

    function automatic logic [31:0] read_reg(input i2cws_state_t s, input logic [31:0] x);
        logic [4:0] sl;
        sl = idx_slot(s.reg_addr);
        if (s.reg_addr == `I2CWS_CTRL_OFS)
            return {21'h0, s.launch, s.ena, s.st_index};
        else if (s.reg_addr == `I2CWS_STATUS_OFS)
            return {31'h0, s.busy};
        else if (s.reg_addr == `I2CWS_TRIG_OFS)
            return 32'h0000_0000;
        else if (!sl[4])
            return {23'h0, s.trg_idx[sl[3:0]]};
        else if (mem_hit(s.reg_addr))
            return s.mem[mem_slot(s.reg_addr)];
        else
            return x;
    endfunction

    function automatic logic [7:0] tx_byte(input logic [31:0] w, input logic wd_, input logic [1:0] d);
        logic [31:0] t;
        t = w << {d, 3'b000};
        return wd_ ? t[31:24] : t[15:8];
    endfunction

    function automatic logic [3:0] lowest(input logic [15:0] p);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 15; i >= 0; i--)
            if (p[i])
                r = 4'(i);
        return r;
    endfunction

    // Filtered pins change once the second and third stages agree
    assign scl_nf   = (s_r.scl_s[1] == s_r.scl_s[2]) ? s_r.scl_s[2] : s_r.scl_f;
    assign sda_nf   = (s_r.sda_s[1] == s_r.sda_s[2]) ? s_r.sda_s[2] : s_r.sda_f;
    assign scl_rise = clk_en && !s_r.scl_f && scl_nf;
    assign scl_fall = clk_en && s_r.scl_f && !scl_nf;
    assign start_c  = clk_en && s_r.scl_f && scl_nf && s_r.sda_f && !sda_nf;
    assign stop_c   = clk_en && s_r.scl_f && scl_nf && !s_r.sda_f && sda_nf;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.scl_s = {s_r.scl_s[1:0], scl_in};
        s_nxt.sda_s = {s_r.sda_s[1:0], sda_in};
        s_nxt.scl_f = scl_nf;
        s_nxt.sda_f = sda_nf;
        s_nxt.wr.valid = 1'b0;
        s_nxt.sda_out = 1'b0;
        wr_word = 1'b0;
        wd = {s_r.wacc[23:0], s_r.sh};
        load_tx = 1'b0;
        abort_req = 1'b0;
        seq_issue = 1'b0;
        seq_done = 1'b0;
        cmd = s_r.mem[s_r.ptr];
        pick_idx = s_r.st_index;
        k = lowest(s_r.pend);
        wslot = idx_slot(s_r.reg_addr);
        if (start_c)
        begin
            s_nxt.phase = PH_RX;
            s_nxt.bcnt = 4'h0;
            s_nxt.byte_idx = 3'h0;
            s_nxt.sda_oe = 1'b0;
        end
        else if (stop_c)
        begin
            s_nxt.phase = PH_IDLE;
            s_nxt.sda_oe = 1'b0;
        end
        else if (scl_rise)
        begin
            case (s_r.phase)
                PH_RX:
                begin
                    s_nxt.sh = {s_r.sh[6:0], sda_nf};
                    s_nxt.bcnt = s_r.bcnt + 4'h1;
                end
                PH_TX:
                    s_nxt.bcnt = s_r.bcnt + 4'h1;
                PH_MACK:
                    if (sda_nf)
                        s_nxt.phase = PH_IDLE;
                    else
                    begin
                        // Pointer steps on the rise so outside read data settles by the fall
                        s_nxt.dcnt = s_r.dcnt + 2'h1;
                        if (s_r.dcnt == (wide(s_r.reg_addr) ? 2'h3 : 2'h1))
                        begin
                            s_nxt.dcnt = 2'h0;
                            s_nxt.reg_addr = s_r.reg_addr + 32'h0000_0001;
                        end
                    end
                default:
                    s_nxt.bcnt = s_r.bcnt;
            endcase
        end
        else if (scl_fall)
        begin
            case (s_r.phase)
                PH_RX:
                    if (s_r.bcnt == 4'h8)
                    begin
                        s_nxt.bcnt = 4'h0;
                        s_nxt.phase = PH_ACK;
                        s_nxt.sda_oe = 1'b1;
                        if (s_r.byte_idx == 3'h0)
                        begin
                            s_nxt.dcnt = 2'h0;
                            s_nxt.rd_mode = s_r.sh[0];
                            s_nxt.byte_idx = s_r.sh[0] ? 3'h5 : 3'h1;
                            if (s_r.sh[7:1] != DEV_ID[7:1])
                            begin
                                s_nxt.phase = PH_IDLE;
                                s_nxt.sda_oe = 1'b0;
                            end
                        end
                        else if (s_r.byte_idx != 3'h5)
                        begin
                            s_nxt.reg_addr = {s_r.reg_addr[23:0], s_r.sh};
                            s_nxt.byte_idx = s_r.byte_idx + 3'h1;
                        end
                        else
                        begin
                            s_nxt.wacc = wd;
                            s_nxt.dcnt = s_r.dcnt + 2'h1;
                            if (s_r.dcnt == (wide(s_r.reg_addr) ? 2'h3 : 2'h1))
                            begin
                                wr_word = 1'b1;
                                s_nxt.dcnt = 2'h0;
                                s_nxt.reg_addr = s_r.reg_addr + 32'h0000_0001;
                            end
                        end
                    end
                PH_ACK:
                begin
                    s_nxt.sda_oe = 1'b0;
                    s_nxt.phase = PH_RX;
                    load_tx = s_r.rd_mode;
                end
                PH_TX:
                    if (s_r.bcnt == 4'h8)
                    begin
                        s_nxt.sda_oe = 1'b0;
                        s_nxt.phase = PH_MACK;
                    end
                    else
                    begin
                        s_nxt.sh = {s_r.sh[6:0], 1'b0};
                        s_nxt.sda_oe = !s_r.sh[6];
                    end
                PH_MACK:
                    load_tx = 1'b1;
                default:
                    s_nxt.sda_oe = 1'b0;
            endcase
        end
        if (load_tx)
        begin
            if (s_nxt.dcnt == 2'h0)
                s_nxt.rword = read_reg(s_nxt, ext_rd_data);
            s_nxt.sh = tx_byte(s_nxt.rword, wide(s_nxt.reg_addr), s_nxt.dcnt);
            s_nxt.sda_oe = !s_nxt.sh[7];
            s_nxt.bcnt = 4'h0;
            s_nxt.phase = PH_TX;
        end
        // Sequencer steps before host writes so a fresh launch or trigger survives
        if (s_r.run)
        begin
            if (cmd[`I2CWS_CMD_END_BIT])
                seq_done = 1'b1;
            else if (!wr_word)
            begin
                seq_issue = 1'b1;
                s_nxt.wr.valid = 1'b1;
                s_nxt.wr.addr = {17'h0, cmd[30:16]};
                s_nxt.wr.data = {16'h0, cmd[15:0]};
                s_nxt.ptr = s_r.ptr + 9'h001;
                seq_done = s_r.ptr == `I2CWS_IDX_LAST;
            end
        end
        else if (s_r.launch || |s_r.pend)
        begin
            if (!s_r.launch)
            begin
                pick_idx = s_r.trg_idx[k];
                s_nxt.pend[k] = 1'b0;
            end
            s_nxt.cur_launch = s_r.launch;
            if (pick_idx > `I2CWS_IDX_LAST)
                s_nxt.launch = 1'b0;
            else
            begin
                s_nxt.run = 1'b1;
                s_nxt.ptr = pick_idx;
            end
        end
        if (seq_done)
        begin
            s_nxt.run = 1'b0;
            if (s_r.cur_launch)
                s_nxt.launch = 1'b0;
        end
        if (wr_word)
        begin
            if (s_r.reg_addr == `I2CWS_CTRL_OFS)
            begin
                s_nxt.ena = wd[`I2CWS_ENABLE_BIT];
                s_nxt.st_index = wd[8:0];
                abort_req = wd[`I2CWS_ABORT_BIT] && s_r.run;
                if (wd[`I2CWS_LAUNCH_BIT] && wd[`I2CWS_ENABLE_BIT])
                    s_nxt.launch = 1'b1;
            end
            else if (s_r.reg_addr == `I2CWS_TRIG_OFS)
                s_nxt.pend = s_nxt.pend | wd[15:0];
            else if (!wslot[4])
                s_nxt.trg_idx[wslot[3:0]] = wd[8:0];
            else if (mem_hit(s_r.reg_addr))
                s_nxt.mem[mem_slot(s_r.reg_addr)] = wd;
            else if (s_r.reg_addr != `I2CWS_STATUS_OFS)
            begin
                s_nxt.wr.valid = 1'b1;
                s_nxt.wr.addr = s_r.reg_addr;
                s_nxt.wr.data = wd;
            end
        end
        if (abort_req)
        begin
            s_nxt.run = 1'b0;
            if (s_r.cur_launch)
                s_nxt.launch = 1'b0;
        end
        s_nxt.busy = s_nxt.run || s_nxt.launch || |s_nxt.pend;
        if (!resetn)
        begin
            s_nxt = '0;
            s_nxt.mem = s_r.mem;
            s_nxt.scl_s = 3'h7;
            s_nxt.sda_s = 3'h7;
            s_nxt.scl_f = 1'b1;
            s_nxt.sda_f = 1'b1;
            s_nxt.st_index = `I2CWS_START_RESET;
            s_nxt.trg_idx = {16{`I2CWS_IDX_RESET}};
        end
    end

    // Runs on the block clock only; no system clock is involved
    always_ff @(posedge clock)
    begin
        if (clk_en || !resetn)
            s_r <= s_nxt;
    end

    assign sda_out     = s_r.sda_out;
    assign sda_oe      = s_r.sda_oe;
    assign reg_rd_addr = s_r.reg_addr;
    assign reg_wr      = s_r.wr;
    assign seq_busy    = s_r.busy;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    sequence s_dev_byte;
        s_r.phase == PH_RX && scl_fall && s_r.bcnt == 4'h8 && s_r.byte_idx == 3'h0;
    endsequence
    sequence s_host_abort;
        wr_word && s_r.reg_addr == `I2CWS_CTRL_OFS && wd[`I2CWS_ABORT_BIT] && s_r.run;
    endsequence

    a_sda_low_only: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    a_start_rx: assert property (start_c |=> s_r.phase == PH_RX && s_r.bcnt == 4'h0)
        else $error("start not followed by receive");
    a_stop_idle: assert property (stop_c |=> s_r.phase == PH_IDLE && !sda_oe)
        else $error("stop not returning to idle");
    a_ack_match: assert property (s_dev_byte ##0 s_r.sh[7:1] == 7'h1A |=> sda_oe)
        else $error("own address not acknowledged");
    a_miss_idle: assert property (s_dev_byte ##0 s_r.sh[7:1] != 7'h1A |=> !sda_oe ##0 s_r.phase == PH_IDLE)
        else $error("foreign address acknowledged");
    a_addr_step: assert property (wr_word |=> s_r.reg_addr == $past(s_r.reg_addr) + 32'h0000_0001)
        else $error("address not advanced after word");
    a_abort_one: assert property (s_host_abort |=> !s_r.run && (s_r.pend | $past(s_r.pend)) == s_r.pend)
        else $error("abort lost pending requests");
    a_ptr_order: assert property (clk_en && seq_issue && !seq_done |=> s_r.run && s_r.ptr == $past(s_r.ptr) + 9'h001)
        else $error("sequencer skipped an index");
    a_launch_clr: assert property (clk_en && seq_done && s_r.cur_launch && !wr_word |=> !s_r.launch)
        else $error("launch bit not cleared");
    a_none_index: assert property (clk_en && !s_r.run && !s_r.launch && |s_r.pend && s_r.trg_idx[k] == 9'h1FF |=> !s_r.run)
        else $error("index 0x1FF executed");
endmodule
`default_nettype wire

// ==== design/i2cws_params.svh ====
// Offsets, field positions, reset values and counts of the two-wire port and sequencer
`ifndef I2CWS_PARAMS_SVH
`define I2CWS_PARAMS_SVH
`define I2CWS_DEV_ID        8'h34
`define I2CWS_CTRL_OFS      32'h0000_0016
`define I2CWS_STATUS_OFS    32'h0000_0018
`define I2CWS_TRIG_OFS      32'h0000_0042
`define I2CWS_IDXA_OFS      32'h0000_004B
`define I2CWS_IDXA_CNT      32'h0000_0006
`define I2CWS_IDXB_OFS      32'h0000_0059
`define I2CWS_IDXB_CNT      32'h0000_0006
`define I2CWS_IDXC_OFS      32'h0000_0068
`define I2CWS_IDXC_CNT      32'h0000_0004
`define I2CWS_MEM_OFS       32'h0000_3000
`define I2CWS_MEM_LAST_OFS  32'h0000_33F6
`define I2CWS_WIDE_OFS      32'h0000_3000
`define I2CWS_MEM_DEPTH     508
`define I2CWS_IDX_LAST      9'h1FB
`define I2CWS_IDX_NONE      9'h1FF
`define I2CWS_IDX_RESET     9'h1FF
`define I2CWS_START_RESET   9'h000
`define I2CWS_ABORT_BIT     11
`define I2CWS_LAUNCH_BIT    10
`define I2CWS_ENABLE_BIT    9
`define I2CWS_CMD_END_BIT   31
`endif

// ==== design/i2cws_pkg.sv ====
// Types of the two-wire control port and write sequencer
`include "i2cws_params.svh"
package i2cws_pkg;
    typedef enum logic [2:0] {PH_IDLE, PH_RX, PH_ACK, PH_TX, PH_MACK} i2cws_phase_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [31:0] data;
    } i2cws_wr_t;

    typedef struct packed {
        logic [2:0]                         scl_s;
        logic [2:0]                         sda_s;
        logic                               scl_f;
        logic                               sda_f;
        i2cws_phase_t                       phase;
        logic [7:0]                         sh;
        logic [3:0]                         bcnt;
        logic [2:0]                         byte_idx;
        logic [1:0]                         dcnt;
        logic                               rd_mode;
        logic [31:0]                        reg_addr;
        logic [31:0]                        wacc;
        logic [31:0]                        rword;
        logic                               sda_oe;
        logic                               sda_out;
        i2cws_wr_t                          wr;
        logic                               ena;
        logic                               launch;
        logic [8:0]                         st_index;
        logic [15:0]                        pend;
        logic [15:0][8:0]                   trg_idx;
        logic                               run;
        logic                               cur_launch;
        logic [8:0]                         ptr;
        logic                               busy;
        logic [`I2CWS_MEM_DEPTH-1:0][31:0]  mem;
    } i2cws_state_t;
endpackage

// ==== verification/i2cws_master.sv ====
// Two-wire bus master model standing in for the host processor
`timescale 1ns/10ps
`default_nettype none
`include "i2cws_params.svh"
module i2cws_master
(
    // Clock and resolved data line
    input  wire logic clock,
    input  wire logic sda_line,
    // Open-drain drives, high pulls the line low
    output logic      scl_low,
    output logic      sda_low
);
    localparam int Q = 8;

    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    // One quarter bit with both lines held
    task automatic step(input logic s, input logic d);
        scl_low <= s;
        sda_low <= d;
        repeat (Q) @(negedge clock);
    endtask

    // Works from idle and as repeated start
    task automatic start_cond();
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
    endtask

    task automatic stop_cond();
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        step(1'b0, 1'b0);
    endtask

    task automatic bit_out(input logic v);
        step(1'b1, !v);
        step(1'b0, !v);
        step(1'b0, !v);
        step(1'b1, !v);
    endtask

    task automatic bit_in(output logic v);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        v = sda_line;
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
    endtask

    task automatic send_byte(input logic [7:0] x, output logic ack);
        logic v;
        for (int i = 7; i >= 0; i--)
            bit_out(x[i]);
        bit_in(v);
        ack = !v;
    endtask

    task automatic recv_byte(output logic [7:0] x, input logic last);
        for (int i = 7; i >= 0; i--)
            bit_in(x[i]);
        bit_out(last);
    endtask

    // Address phase, optional turn-around, data bytes, stop
    task automatic xfer(input logic [7:0] id, input logic [31:0] a, input int n,
                        ref logic [7:0] d [16], output logic ok);
        logic k;
        start_cond();
        send_byte(id & 8'hFE, ok);
        for (int i = 3; i >= 0; i--)
        begin
            send_byte(a[8*i+:8], k);
            ok &= k;
        end
        if (id[0])
        begin
            start_cond();
            send_byte(id, k);
            ok &= k;
        end
        for (int i = 0; i < n; i++)
        begin
            if (id[0])
                recv_byte(d[i], i == n - 1);
            else
            begin
                send_byte(d[i], k);
                ok &= k;
            end
        end
        stop_cond();
    endtask
endmodule
`default_nettype wire

// ==== verification/i2cws_top_bench.sv ====
// Self-checking bench of the two-wire control port and write sequencer
`timescale 1ns/10ps
`default_nettype none
`include "i2cws_params.svh"
`define CHECK(what, exp, got) \
    begin n_checks++; if ((got) !== (exp)) begin failures++; \
    $display("MISMATCH %s expected %h seen %h", what, exp, got); end end
module i2cws_top_bench;
    import i2cws_pkg::*;
    logic        clock;
    logic        resetn;
    logic        clk_en;
    logic        scl_in;
    logic        sda_in;
    logic        sda_out;
    logic        sda_oe;
    logic        seq_busy;
    logic        scl_low;
    logic        sda_low;
    logic        ok;
    logic [31:0] ext_rd_data;
    logic [31:0] reg_rd_addr;
    i2cws_wr_t   reg_wr;
    logic [7:0]  b [16];
    logic [31:0] wq [$];
    int          failures = 0;
    int          n_checks = 0;

    i2cws_top i_i2cws_top (.clock(clock), .resetn(resetn), .clk_en(clk_en),
        .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
        .ext_rd_data(ext_rd_data), .reg_rd_addr(reg_rd_addr), .reg_wr(reg_wr),
        .seq_busy(seq_busy));
    i2cws_master i_i2cws_master (.clock(clock), .sda_line(sda_in), .scl_low(scl_low),
        .sda_low(sda_low));

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Outside register map answers a pattern of the address
    assign ext_rd_data = {2{reg_rd_addr[15:0] ^ 16'h5A5A}};

    always @(negedge clock)
    begin
        scl_in <= ~scl_low;
        sda_in <= ~(sda_low | sda_oe);
    end

    always @(negedge clock)
    begin
        if (resetn === 1'b1 && reg_wr.valid === 1'b1)
            wq.push_back({reg_wr.addr[15:0], reg_wr.data[15:0]});
        if (sda_oe === 1'b1)
            `CHECK("data drive level", 1'b0, sda_out)
    end

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic do_reset();
        resetn = 1'b0;
        repeat (12) @(negedge clock);
        resetn = 1'b1;
        repeat (4) @(negedge clock);
    endtask

    task automatic wr(input logic [31:0] a, input int n, input logic [31:0] d);
        for (int i = 0; i < n; i++)
            b[i] = d[8*(n-1-i)+:8];
        i_i2cws_master.xfer(`I2CWS_DEV_ID, a, n, b, ok);
        `CHECK("write ack", 1'b1, ok)
    endtask

    task automatic rd(input logic [31:0] a, input int n, output logic [31:0] d);
        i_i2cws_master.xfer(`I2CWS_DEV_ID | 8'h01, a, n, b, ok);
        d = '0;
        for (int i = 0; i < n; i++)
            d = {d[23:0], b[i]};
        `CHECK("read ack", 1'b1, ok)
    endtask

    task automatic expect_wr(input logic [31:0] e);
        logic [31:0] g;
        g = (wq.size() > 0) ? wq.pop_front() : 32'hxxxx_xxxx;
        `CHECK("register write", e, g)
    endtask

    task automatic wait_idle();
        int k;
        k = 0;
        while (seq_busy !== 1'b0 && k < 2000)
        begin
            @(negedge clock);
            k++;
        end
        if (k == 2000)
        begin
            failures++;
            conclude();
        end
    endtask

    initial
    begin
        logic [31:0] v;
        clk_en = 1'b1;
        do_reset();
        wr(32'h0000_1234, 2, 32'h0000_BEEF);
        expect_wr(32'h1234_BEEF);
        wr(32'h0000_0100, 4, 32'h1122_3344);
        expect_wr(32'h0100_1122);
        expect_wr(32'h0101_3344);
        i_i2cws_master.xfer(8'h36, 32'h0000_1234, 2, b, ok);
        `CHECK("foreign id ack", 1'b0, ok)
        i_i2cws_master.xfer(`I2CWS_DEV_ID, 32'h0000_0300, 1, b, ok);
        clk_en = 1'b0;
        i_i2cws_master.xfer(`I2CWS_DEV_ID, 32'h0000_1234, 2, b, ok);
        `CHECK("frozen port ack", 1'b0, ok)
        clk_en = 1'b1;
        `CHECK("stray writes", 0, wq.size())
        rd(32'h0000_0200, 4, v);
        `CHECK("burst read", {16'h0200 ^ 16'h5A5A, 16'h0201 ^ 16'h5A5A}, v)
        $display("Test link access done");
        wr(32'h0000_300A, 4, 32'h0123_AAAA);
        wr(32'h0000_300C, 4, 32'h0124_BBBB);
        wr(32'h0000_300E, 4, 32'h8000_0000);
        wr(32'h0000_33F6, 4, 32'h0126_DDDD);
        rd(32'h0000_300A, 4, v);
        `CHECK("memory read", 32'h0123_AAAA, v)
        wr(`I2CWS_IDXA_OFS, 2, 32'h0000_0005);
        wr(`I2CWS_IDXA_OFS + 32'h0000_0002, 2, 32'h0000_0006);
        wr(`I2CWS_TRIG_OFS, 2, 32'h0000_0005);
        wait_idle();
        expect_wr(32'h0123_AAAA);
        expect_wr(32'h0124_BBBB);
        expect_wr(32'h0124_BBBB);
        wr(`I2CWS_TRIG_OFS, 2, 32'h0000_0002);
        wait_idle();
        `CHECK("dropped sequence writes", 0, wq.size())
        $display("Test triggers done");
        wr(`I2CWS_CTRL_OFS, 2, 32'h0000_07FB);
        wait_idle();
        expect_wr(32'h0126_DDDD);
        rd(`I2CWS_CTRL_OFS, 2, v);
        `CHECK("launch bit self-clear", 32'h0000_03FB, v)
        rd(`I2CWS_STATUS_OFS, 2, v);
        `CHECK("busy status", 32'h0000_0000, v)
        $display("Test launch done");
        do_reset();
        rd(`I2CWS_IDXA_OFS, 2, v);
        `CHECK("trigger index reset", 32'h0000_01FF, v)
        wr(`I2CWS_CTRL_OFS, 2, 32'h0000_07FB);
        wait_idle();
        expect_wr(32'h0126_DDDD);
        `CHECK("leftover writes", 0, wq.size())
        $display("Test memory retention done");
        conclude();
    end
endmodule
`default_nettype wire
